/* bench/rasirq_irq_host.sv */
`timescale 1ns/1ns
module rasirq_irq_host
   import rasirq_pkg::*;
(
   input wire logic i_clock, // Clock
   input wire logic i_rst, // Cold reset
   input wire rasirq_irq_t i_irq, // Interrupt lines from the node
   output logic [7:0] o_crit_taken // Critical requests taken
);
   logic crit_q_r;
   ////////////////////////////////////////////////////////////////////////
   // A level request is taken once, when it rises
   always_ff @(posedge i_clock) begin
      crit_q_r <= i_rst ? 1'b0 : i_irq.critical;
      if (i_rst) begin
         o_crit_taken <= 8'h00;
      end else if (i_irq.critical && !crit_q_r) begin
         o_crit_taken <= o_crit_taken + 8'h01;
      end
   end
endmodule : rasirq_irq_host

/* bench/rasirq_node_props.sv */
`timescale 1ns/1ns
module rasirq_node_props
   import rasirq_pkg::*;
#(
   parameter bit EDGE_MODE = 1'b0
) (
   input wire logic i_clock, // Clock
   input wire logic i_rst, // Cold reset
   input wire logic i_rec_rst, // Recovery reset
   input wire rasirq_err_t i_err, // Error report
   input wire logic [3:0] i_addr, // Address
   input wire logic [31:0] i_wdata, // Write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   input wire logic [31:0] o_rdata, // Read data
   input wire logic o_fault_irq, // Fault irq
   input wire logic o_recovery_irq, // Recovery irq
   input wire logic o_critical_irq, // Critical irq
   input wire logic o_abort // Abort pulse
);
   logic [31:0] ctl_r;
   logic [31:0] ctl_nxt;
   logic quiet;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the control register
   always_comb begin
      ctl_nxt = ctl_r;
      if (i_rst || i_rec_rst) begin
         ctl_nxt = RASIRQ_CONTROL_RST;
      end else if (i_wr && i_addr == RASIRQ_OFS_CONTROL) begin
         ctl_nxt = i_wdata;
      end
   end
   always_ff @(posedge i_clock) begin
      ctl_r <= ctl_nxt;
   end
   assign quiet = !i_wr && !i_rec_rst;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   reset_quiet_a: assert property (disable iff (1'b0) i_rst |=>
      !o_fault_irq && !o_recovery_irq && !o_critical_irq && !o_abort)
      else $error("outputs active after cold reset");
   abort_gate_a: assert property (o_abort |-> $past(ctl_r[RASIRQ_CT_ABT]
      && i_err.valid && i_err.abort_req)) else $error("abort not enabled");
   crit_enable_a: assert property (o_critical_irq |->
      ctl_r[RASIRQ_CT_CI]) else $error("critical irq while disabled");
   rec_enable_a: assert property (o_recovery_irq |->
      ctl_r[RASIRQ_CT_UI] || ctl_r[RASIRQ_CT_DUI])
      else $error("recovery irq while disabled");
   fault_enable_a: assert property (o_fault_irq |->
      ctl_r[RASIRQ_CT_FI] || ctl_r[RASIRQ_CT_CFI])
      else $error("fault irq while disabled");
   deferred_rec_a: assert property (i_err.valid && i_err.deferred &&
      !i_err.corrected && !i_err.critical && ctl_r[RASIRQ_CT_DUI] && quiet
      |=> o_recovery_irq) else $error("deferred error missed recovery");
   crit_flag_a: assert property (i_err.valid && i_err.critical &&
      ctl_r[RASIRQ_CT_CI] && quiet |=> o_critical_irq)
      else $error("critical error missed critical irq");
   crit_unc_a: assert property (i_err.valid && i_err.critical &&
      !ctl_r[RASIRQ_CT_CI] && ctl_r[RASIRQ_CT_UI] && quiet |=> o_recovery_irq)
      else $error("disabled critical missed recovery");
   rec_hold_a: assert property (!EDGE_MODE && o_recovery_irq &&
      quiet |=> o_recovery_irq) else $error("recovery irq dropped");
   crit_pulse_a: assert property (EDGE_MODE && o_critical_irq &&
      !(i_err.valid && i_err.critical) |=> !o_critical_irq)
      else $error("critical pulse longer than one cycle");
   cover property (o_abort);
   cover property (o_critical_irq);
   cover property (o_fault_irq && o_recovery_irq);
endmodule : rasirq_node_props
bind rasirq_node rasirq_node_props #(.EDGE_MODE(EDGE_MODE)) u_props (
   .i_clock(i_clock), .i_rst(i_rst),
   .i_rec_rst(i_rec_rst), .i_err(i_err), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fault_irq(o_fault_irq),
   .o_recovery_irq(o_recovery_irq), .o_critical_irq(o_critical_irq),
   .o_abort(o_abort));

/* bench/rasirq_node_tb_top.sv */
`timescale 1ns/1ns
module rasirq_node_tb_top;
   import rasirq_pkg::*;
   logic i_clock, i_rst, i_rec_rst, i_wr, i_rd, o_fault_irq, o_recovery_irq;
   logic o_critical_irq, o_abort;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d, t;
   logic [7:0] crit_n;
   logic [2:0] edge_irq;
   rasirq_err_t i_err;
   int err_total, n_compared, cyc, seed, m_ctl, m_st, n_rep, n_oth, n;
   ////////////////////////////////////////////////////////////////////////
   rasirq_node dut (.i_clock(i_clock), .i_rst(i_rst), .i_rec_rst(i_rec_rst),
      .i_err(i_err), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_fault_irq(o_fault_irq),
      .o_recovery_irq(o_recovery_irq), .o_critical_irq(o_critical_irq),
      .o_abort(o_abort));
   rasirq_node #(.EDGE_MODE(1'b1)) dut_edge (.i_clock(i_clock),
      .i_rst(i_rst), .i_rec_rst(i_rec_rst), .i_err(i_err), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(),
      .o_fault_irq(edge_irq[2]), .o_recovery_irq(edge_irq[1]),
      .o_critical_irq(edge_irq[0]), .o_abort());
   rasirq_irq_host host (.i_clock(i_clock), .i_rst(i_rst),
      .i_irq({o_fault_irq, o_recovery_irq, o_critical_irq}),
      .o_crit_taken(crit_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Expected interrupt levels from the control and status model
   task automatic cmp_irq();
      logic v;
      logic [2:0] e;
      #1;
      v = m_st[RASIRQ_ST_V];
      e[2] = v && (m_ctl[RASIRQ_CT_FI] && (m_st[RASIRQ_ST_UE] ||
         m_st[RASIRQ_ST_DE]) || m_ctl[RASIRQ_CT_CFI] && m_st[RASIRQ_ST_OFR]);
      e[1] = v && (m_ctl[RASIRQ_CT_UI] && m_st[RASIRQ_ST_UE] ||
         m_ctl[RASIRQ_CT_DUI] && m_st[RASIRQ_ST_DE]);
      e[0] = v && m_ctl[RASIRQ_CT_CI] && m_st[RASIRQ_ST_CI];
      n_compared++;
      if ({o_fault_irq, o_recovery_irq, o_critical_irq} !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
            {o_fault_irq, o_recovery_irq, o_critical_irq}, e);
      end
   endtask : cmp_irq
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      if (a == RASIRQ_OFS_CONTROL) m_ctl = v;
      if (a == RASIRQ_OFS_STATUS) m_st = m_st & ~v;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask : rd
   task automatic rd_st();
      rd(RASIRQ_OFS_STATUS, d);
      cmp(d & 32'h3e7, m_st & 32'h3e7);
   endtask : rd_st
   // Edge pulses expected from the error kind and the enables
   task automatic err(input logic c, dd, k, s, ab);
      logic u, f, ev;
      logic [2:0] e;
      u = (k && !m_ctl[RASIRQ_CT_CI]) || (!c && !dd);
      f = dd && !c && !(k && !m_ctl[RASIRQ_CT_CI]);
      @(posedge i_clock);
      i_err <= '{1'b1, c, dd, k, s, ab, $random(seed)};
      @(posedge i_clock);
      i_err.valid <= 1'b0;
      m_st |= 1 << RASIRQ_ST_V;
      if (k) m_st |= 1 << RASIRQ_ST_CI;
      if (k && !m_ctl[RASIRQ_CT_CI]) m_st |= 32'h82;
      else if (!c) m_st |= dd ? 32'h4 : 32'h2;
      if (!c && !dd && ab && m_ctl[RASIRQ_CT_ABT]) m_st |= 32'h40;
      if (c && !s) n_oth++;
      if (c && s) n_rep = (n_rep + 1) % 256;
      if (c && s && n_rep == 0) m_st |= 1 << RASIRQ_ST_OFR;
      ev = c && (s ? n_rep == 0 : n_oth % 256 == 0);
      e[2] = m_ctl[RASIRQ_CT_FI] && (u || f) || m_ctl[RASIRQ_CT_CFI] && ev;
      e[1] = m_ctl[RASIRQ_CT_UI] && u || m_ctl[RASIRQ_CT_DUI] && f;
      e[0] = m_ctl[RASIRQ_CT_CI] && k;
      #1 cmp({29'h0, edge_irq}, {29'h0, e});
   endtask : err
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      seed = 32'he7f738e3;
      {i_rst, i_rec_rst, i_wr, i_rd, i_addr, i_wdata} = 40'h80_0000_0000;
      i_err = '0;
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(RASIRQ_OFS_FEATURE, d);
      cmp(d, 32'h35);
      rd(RASIRQ_OFS_CONTROL, d);
      cmp(d, 32'h0);
      rd(4'hf, d);
      cmp(d, 32'h0);
      rd_st();
      $display("test reset done");
      wr(RASIRQ_OFS_CONTROL, 32'h8);
      err(0, 1, 0, 0, 0);
      cmp_irq();
      wr(RASIRQ_OFS_CONTROL, 32'h9);
      cmp_irq();
      rd_st();
      wr(RASIRQ_OFS_STATUS, 32'h3ff);
      cmp_irq();
      $display("test deferred done");
      wr(RASIRQ_OFS_CONTROL, 32'h14);
      err(0, 1, 1, 0, 0);
      cmp_irq();
      rd_st();
      wr(RASIRQ_OFS_STATUS, 32'h3ff);
      wr(RASIRQ_OFS_CONTROL, 32'h4);
      err(0, 1, 1, 0, 0);
      cmp_irq();
      rd_st();
      cmp({24'h0, crit_n}, 32'h1);
      wr(RASIRQ_OFS_STATUS, 32'h3ff);
      $display("test critical done");
      wr(RASIRQ_OFS_CONTROL, 32'h2);
      n = ($random(seed) & 7) + 1;
      repeat (n) err(1, 0, 0, 0, 0);
      repeat (255) err(1, 0, 0, 1, 0);
      cmp_irq();
      rd(RASIRQ_OFS_MISC0, d);
      cmp(d, (n_oth << 16) | n_rep);
      err(1, 0, 0, 1, 0);
      cmp_irq();
      rd(RASIRQ_OFS_MISC0, d);
      cmp(d, (n_oth << 16) | n_rep);
      rd_st();
      wr(RASIRQ_OFS_STATUS, 32'h3ff);
      $display("test counter done");
      wr(RASIRQ_OFS_CONTROL, 32'h0);
      err(0, 0, 0, 0, 1);
      #1 cmp({31'h0, o_abort}, 32'h0);
      wr(RASIRQ_OFS_CONTROL, 32'h2c);
      err(0, 0, 0, 0, 1);
      cmp_irq();
      cmp({31'h0, o_abort}, 32'h1);
      err(0, 1, 0, 0, 0);
      rd_st();
      rd(RASIRQ_OFS_MISC3_LO, d);
      cmp({31'h0, |d}, 32'h1);
      $display("test abort done");
      @(posedge i_clock);
      i_rec_rst <= 1'b1;
      @(posedge i_clock);
      i_rec_rst <= 1'b0;
      m_ctl = 0;
      cmp_irq();
      rd_st();
      rd(RASIRQ_OFS_TIME_LO, t);
      rd(RASIRQ_OFS_TIME_LO, d);
      cmp(d - t, 32'h2);
      @(posedge i_clock);
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
      m_st = 0;
      rd_st();
      rd(RASIRQ_OFS_MISC0, d);
      cmp(d, 32'h0);
      $display("test resets done");
      wrap_up();
   end
endmodule : rasirq_node_tb_top

/* core/rasirq_node.sv */
`timescale 1ns/1ns
// Function
// - Critical interrupt exists when feature field nonzero
// - Critical support implies recovery interrupt support
// - Critical interrupt enabled by control bit
// - Recorded critical condition always sets critical flag
// - Disabled critical recorded as uncontained, raises recovery
// - Enabled critical: flag plus normal syndrome
// - Paired counters: repeat location, other location
// - Fault interrupt on enabled counter overflow
// - Level fault: valid and deferred or uncorrected
// - Level fault: valid and counter overflow
// - Level fault without counter: valid, corrected field
// - Level recovery: valid and uncorrected flag
// - Level recovery: valid and deferred flag
// - Level critical: enabled, valid and critical flag
// - Edge fault pulse on uncorrected, deferred or corrected event
// - Edge recovery pulse on uncorrected or deferred
// - Edge critical pulse on every critical record while enabled
// - Edge pulses even when syndrome is discarded
// - Interrupt outputs updated within bounded cycles
// - Cold reset clears all; recovery reset keeps syndrome
// - Timestamp when field nonzero, stored in misc three
// - Timebase binary, monotonic, fixed rate
// - Abort only when enabled; sets abort reported flag
module rasirq_node
   import rasirq_pkg::*;
#(
   parameter logic [1:0] CRIT_SUPPORT = 2'h1,
   parameter logic [1:0] TS_SUPPORT = 2'h1,
   parameter bit HAS_COUNTER = 1'b1,
   parameter bit PAIRED = 1'b1,
   parameter bit EDGE_MODE = 1'b0,
   parameter logic [31:0] TIME_STEP = 32'h0000_0001
) (
   input wire logic i_clock,           // 25 MHz clock
   input wire logic i_rst,             // Cold reset, sync, high
   input wire logic i_rec_rst,         // Error recovery reset, sync, high
   input wire rasirq_err_t i_err,      // Detected error report
   input wire logic [3:0] i_addr,      // Register word address
   input wire logic [31:0] i_wdata,    // Write data
   input wire logic i_wr,              // Write strobe
   input wire logic i_rd,              // Read strobe
   output logic [31:0] o_rdata,        // Read data, cycle after read
   output logic o_fault_irq,           // Fault handling interrupt
   output logic o_recovery_irq,        // Error recovery interrupt
   output logic o_critical_irq,        // Critical error interrupt
   output logic o_abort                // External abort pulse
);

   ////////////////////////////////////////////////////////////////////////
   rasirq_state_t st_r;
   rasirq_state_t st_nxt;
   logic [31:0] feature;
   logic crit_ok;
   logic [1:0] cur_pri;
   logic [1:0] new_pri;
   logic is_ue;
   logic is_de;
   logic is_ce;
   logic ce_event;
   logic rep_ovf;
   logic oth_ovf;
   logic [RASIRQ_CNT_W-1:0] cnt_max;
   rasirq_irq_t lvl;

   assign crit_ok = (CRIT_SUPPORT != 2'h0);
   assign cnt_max = {RASIRQ_CNT_W{1'b1}};

   always_comb begin
      feature = 32'h0000_0000;
      feature[RASIRQ_FR_CI_LSB +: 2] = CRIT_SUPPORT;
      feature[RASIRQ_FR_TS_LSB +: 2] = TS_SUPPORT;
      feature[RASIRQ_FR_CEC_BIT] = HAS_COUNTER;
      feature[RASIRQ_FR_PAIR_BIT] = HAS_COUNTER & PAIRED;
   end

   ////////////////////////////////////////////////////////////////////////
   // Classify the incoming error
   always_comb begin
      is_ce = i_err.valid & i_err.corrected & ~i_err.critical;
      is_de = i_err.valid & i_err.deferred & ~i_err.corrected
         & ~i_err.critical;
      is_ue = i_err.valid & ~i_err.corrected & ~i_err.deferred;
      // Disabled critical is forced uncontained
      if (i_err.valid && i_err.critical && crit_ok) begin
         if (!st_r.control[RASIRQ_CT_CI]) begin
            is_ue = 1'b1;
         end else begin
            is_ue = ~i_err.corrected & ~i_err.deferred;
            is_de = i_err.deferred & ~i_err.corrected;
            is_ce = i_err.corrected;
         end
      end
      new_pri = is_ue ? RASIRQ_PRI_UE : is_de ? RASIRQ_PRI_DE :
         is_ce ? RASIRQ_PRI_CE : RASIRQ_PRI_NONE;
      if (!st_r.status[RASIRQ_ST_V]) begin
         cur_pri = RASIRQ_PRI_NONE;
      end else if (st_r.status[RASIRQ_ST_UE]) begin
         cur_pri = RASIRQ_PRI_UE;
      end else if (st_r.status[RASIRQ_ST_DE]) begin
         cur_pri = RASIRQ_PRI_DE;
      end else begin
         cur_pri = RASIRQ_PRI_CE;
      end
      rep_ovf = is_ce & HAS_COUNTER & (~PAIRED | i_err.same_loc)
         & (st_r.cnt_rep == cnt_max);
      oth_ovf = is_ce & HAS_COUNTER & PAIRED & ~i_err.same_loc
         & (st_r.cnt_oth == cnt_max);
      ce_event = HAS_COUNTER ? (rep_ovf | oth_ovf) : is_ce;
   end

   ////////////////////////////////////////////////////////////////////////
   // Level view of the interrupts
   always_comb begin
      lvl.fault = st_r.control[RASIRQ_CT_FI] & st_r.status[RASIRQ_ST_V]
         & (st_r.status[RASIRQ_ST_DE] | st_r.status[RASIRQ_ST_UE]);
      if (HAS_COUNTER) begin
         lvl.fault = lvl.fault | (st_r.control[RASIRQ_CT_CFI]
            & st_r.status[RASIRQ_ST_V] & (st_r.status[RASIRQ_ST_OFR]
            | st_r.status[RASIRQ_ST_OFO]));
      end else begin
         lvl.fault = lvl.fault | (st_r.control[RASIRQ_CT_CFI]
            & st_r.status[RASIRQ_ST_V] & (st_r.ce_cnt != 2'h0));
      end
      lvl.recovery = st_r.status[RASIRQ_ST_V]
         & ((st_r.control[RASIRQ_CT_UI] & st_r.status[RASIRQ_ST_UE])
         | (st_r.control[RASIRQ_CT_DUI]
         & st_r.status[RASIRQ_ST_DE]));
      lvl.critical = crit_ok & st_r.control[RASIRQ_CT_CI]
         & st_r.status[RASIRQ_ST_V] & st_r.status[RASIRQ_ST_CI];
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.abort = 1'b0;
      st_nxt.timebase = st_r.timebase + {32'h0000_0000, TIME_STEP};

      // Edge pulses from detection, recorded or not
      st_nxt.pulse.fault = (st_r.control[RASIRQ_CT_FI] & (is_ue | is_de))
         | (st_r.control[RASIRQ_CT_CFI] & ce_event);
      st_nxt.pulse.recovery = (st_r.control[RASIRQ_CT_UI] & is_ue)
         | (st_r.control[RASIRQ_CT_DUI] & is_de);
      st_nxt.pulse.critical = crit_ok & st_r.control[RASIRQ_CT_CI]
         & i_err.valid & i_err.critical;

      // Counters
      if (is_ce && HAS_COUNTER) begin
         if (!PAIRED || i_err.same_loc) begin
            st_nxt.cnt_rep = st_r.cnt_rep + 1'b1;
            if (rep_ovf) begin
               st_nxt.status[RASIRQ_ST_OFR] = 1'b1;
            end
         end else begin
            st_nxt.cnt_oth = st_r.cnt_oth + 1'b1;
            if (oth_ovf) begin
               st_nxt.status[RASIRQ_ST_OFO] = 1'b1;
            end
         end
      end

      // Flags set even if syndrome is discarded
      if (i_err.valid) begin
         st_nxt.status[RASIRQ_ST_V] = 1'b1;
         if (is_ue) begin
            st_nxt.status[RASIRQ_ST_UE] = 1'b1;
         end
         if (is_de) begin
            st_nxt.status[RASIRQ_ST_DE] = 1'b1;
         end
         if (is_ce && st_r.ce_cnt != 2'h3) begin
            st_nxt.ce_cnt = st_r.ce_cnt + 2'h1;
         end
         if (i_err.critical && crit_ok) begin
            st_nxt.status[RASIRQ_ST_CI] = 1'b1;
         end
         if (i_err.critical && crit_ok && !st_r.control[RASIRQ_CT_CI]) begin
            st_nxt.status[RASIRQ_ST_UC] = 1'b1;
         end
         if (new_pri >= cur_pri) begin
            st_nxt.syndrome = i_err.syndrome;
            if (TS_SUPPORT != 2'h0) begin
               st_nxt.misc3 = st_r.timebase;
            end
         end
         if (is_ue && i_err.abort_req && st_r.control[RASIRQ_CT_ABT]) begin
            st_nxt.abort = 1'b1;
            st_nxt.status[RASIRQ_ST_ER] = 1'b1;
         end
      end

      // Register port; hardware set wins over software clear
      if (i_wr) begin
         unique case (i_addr)
            RASIRQ_OFS_CONTROL: st_nxt.control = i_wdata;
            RASIRQ_OFS_STATUS: begin
               // Flags clear below; a count bit clears the corrected count
               if (i_wdata[RASIRQ_ST_CE_LSB +: 2] != 2'h0 && !is_ce) begin
                  st_nxt.ce_cnt = 2'h0;
               end
            end
            RASIRQ_OFS_MISC0: begin
               if (!is_ce) begin
                  st_nxt.cnt_rep = i_wdata[RASIRQ_CNT_W-1:0];
                  st_nxt.cnt_oth =
                     i_wdata[RASIRQ_CNT_OTHER_LSB +: RASIRQ_CNT_W];
               end
            end
            default: ;
         endcase
      end
      if (i_wr && i_addr == RASIRQ_OFS_STATUS) begin
         // Reapply this cycle's hardware sets over the clear
         st_nxt.status = (st_r.status & ~i_wdata[9:0]);
         if (i_err.valid) begin
            st_nxt.status[RASIRQ_ST_V] = 1'b1;
            if (is_ue) begin
               st_nxt.status[RASIRQ_ST_UE] = 1'b1;
            end
            if (is_de) begin
               st_nxt.status[RASIRQ_ST_DE] = 1'b1;
            end
            if (i_err.critical && crit_ok) begin
               st_nxt.status[RASIRQ_ST_CI] = 1'b1;
            end
            if (i_err.critical && crit_ok && !st_r.control[RASIRQ_CT_CI]) begin
               st_nxt.status[RASIRQ_ST_UC] = 1'b1;
            end
            if (st_nxt.abort) begin
               st_nxt.status[RASIRQ_ST_ER] = 1'b1;
            end
         end
         if (rep_ovf) begin
            st_nxt.status[RASIRQ_ST_OFR] = 1'b1;
         end
         if (oth_ovf) begin
            st_nxt.status[RASIRQ_ST_OFO] = 1'b1;
         end
      end

      if (i_rd) begin
         unique case (i_addr)
            RASIRQ_OFS_FEATURE: st_nxt.rdata = feature;
            RASIRQ_OFS_CONTROL: st_nxt.rdata = st_r.control;
            RASIRQ_OFS_STATUS: begin
               st_nxt.rdata = {22'h000000, st_r.status};
               st_nxt.rdata[RASIRQ_ST_CE_LSB +: 2] = st_r.ce_cnt;
            end
            RASIRQ_OFS_MISC0: begin
               st_nxt.rdata[RASIRQ_CNT_W-1:0] = st_r.cnt_rep;
               st_nxt.rdata[RASIRQ_CNT_OTHER_LSB +: RASIRQ_CNT_W] =
                  st_r.cnt_oth;
            end
            RASIRQ_OFS_MISC3_LO: st_nxt.rdata = st_r.misc3[31:0];
            RASIRQ_OFS_MISC3_HI: st_nxt.rdata = st_r.misc3[63:32];
            RASIRQ_OFS_TIME_LO: st_nxt.rdata = st_r.timebase[31:0];
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.control <= RASIRQ_CONTROL_RST;
      end else if (i_rec_rst) begin
         // Keep recorded syndrome, counters and timebase
         st_r.control <= RASIRQ_CONTROL_RST;
         st_r.pulse <= '0;
         st_r.abort <= 1'b0;
         st_r.rdata <= 32'h0000_0000;
         st_r.timebase <= st_nxt.timebase;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs settle one cycle after the cause
   assign o_fault_irq = EDGE_MODE ? st_r.pulse.fault : lvl.fault;
   assign o_recovery_irq = EDGE_MODE ? st_r.pulse.recovery : lvl.recovery;
   assign o_critical_irq = EDGE_MODE ? st_r.pulse.critical : lvl.critical;
   assign o_abort = st_r.abort;
   assign o_rdata = st_r.rdata;

endmodule : rasirq_node

/* core/rasirq_pkg.sv */
package rasirq_pkg;
   // Register offsets on the plain register port (word addresses)
   localparam logic [3:0] RASIRQ_OFS_FEATURE = 4'h0;
   localparam logic [3:0] RASIRQ_OFS_CONTROL = 4'h1;
   localparam logic [3:0] RASIRQ_OFS_STATUS = 4'h2;
   localparam logic [3:0] RASIRQ_OFS_MISC0 = 4'h3;
   localparam logic [3:0] RASIRQ_OFS_MISC3_LO = 4'h4;
   localparam logic [3:0] RASIRQ_OFS_MISC3_HI = 4'h5;
   localparam logic [3:0] RASIRQ_OFS_TIME_LO = 4'h6;

   // Feature field positions
   localparam int RASIRQ_FR_CI_LSB = 0;
   localparam int RASIRQ_FR_TS_LSB = 2;
   localparam int RASIRQ_FR_CEC_BIT = 4;
   localparam int RASIRQ_FR_PAIR_BIT = 5;

   // Control bit positions
   localparam int RASIRQ_CT_FI = 0;
   localparam int RASIRQ_CT_CFI = 1;
   localparam int RASIRQ_CT_UI = 2;
   localparam int RASIRQ_CT_DUI = 3;
   localparam int RASIRQ_CT_CI = 4;
   localparam int RASIRQ_CT_ABT = 5;

   // Status bit positions
   localparam int RASIRQ_ST_V = 0;
   localparam int RASIRQ_ST_UE = 1;
   localparam int RASIRQ_ST_DE = 2;
   localparam int RASIRQ_ST_CE_LSB = 3;
   localparam int RASIRQ_ST_CI = 5;
   localparam int RASIRQ_ST_ER = 6;
   localparam int RASIRQ_ST_UC = 7;
   localparam int RASIRQ_ST_OFR = 8;
   localparam int RASIRQ_ST_OFO = 9;

   // Misc0 counter layout: repeat counter low half, other counter high half
   localparam int RASIRQ_CNT_W = 8;
   localparam int RASIRQ_CNT_OTHER_LSB = 16;

   localparam logic [31:0] RASIRQ_CONTROL_RST = 32'h0000_0000;

   // Error severity priority, higher wins the record
   localparam logic [1:0] RASIRQ_PRI_NONE = 2'h0;
   localparam logic [1:0] RASIRQ_PRI_CE = 2'h1;
   localparam logic [1:0] RASIRQ_PRI_DE = 2'h2;
   localparam logic [1:0] RASIRQ_PRI_UE = 2'h3;

   typedef struct packed {
      logic valid;      // Detection this cycle
      logic corrected;  // Error was corrected
      logic deferred;   // Error was deferred
      logic critical;   // Critical condition
      logic same_loc;   // Corrected error repeats a location
      logic abort_req;  // Uncorrected access wants an abort
      logic [31:0] syndrome;
   } rasirq_err_t;

   typedef struct packed {
      logic fault;
      logic recovery;
      logic critical;
   } rasirq_irq_t;

   typedef struct packed {
      logic [31:0] control;
      logic [9:0] status;
      logic [1:0] ce_cnt;
      logic [RASIRQ_CNT_W-1:0] cnt_rep;
      logic [RASIRQ_CNT_W-1:0] cnt_oth;
      logic [31:0] syndrome;
      logic [63:0] misc3;
      logic [63:0] timebase;
      logic [31:0] rdata;
      rasirq_irq_t pulse;
      logic abort;
   } rasirq_state_t;
endpackage : rasirq_pkg
